// ==== cgc_clock_ctrl.sv ====
// Purpose: clock source selection, divider chains, warm-up, power-up hold and watchdog time base
// Assumes: oscillator activity arrives as one-cycle ticks synchronous to aclk
// Notes: analog trim codes leave as register outputs; sleep and global resets are synchronous
// Functional notes
// - power-up hold lasts at least 5 ms before software runs
// - watchdog timeout is at least 2 s on internal oscillators
// - watchdog time base counts trimmed RC ticks, whatever clock is selected
// - three sources: RC oscillator, crystal oscillator, external clock
// - 8-bit high divider on RC or external clock, taps down to 1/256
// - 32 kHz from crystal when enabled, else from chosen high divider tap
// - 15-bit low divider from 32 kHz down to 1 Hz
// - CPU clock from RC, external clock or 32 kHz clock
// - halt stops the CPU clock, other clocks continue
// - control bit 7 CPU speed select, cleared by sleep reset
// - control bit 5 external clock enable, cleared only by cold reset
// - control bit 4 keeps RC bias on, set by cold reset
// - misc bit 1 drives 16 kHz onto port B bit 3, sleep clears
// - misc bit 0 drives CPU clock onto port B bit 2, sleep clears
// - writing 1 to divider clear bit 0 resets low divider, reads 0
// - trim1 bit 4 selects RC range, 0 low, cold reset clears
// - trim1 bits 3..0 coarse trim, cold reset gives 0001
// - range bit scales RC frequency tenfold
// - trim2 bits 5..0 fine trim, about 1.4 percent a step, cold clears
// - crystal warm-up flag masks crystal for 32768 cycles then clears
// - cold and sleep resets enable RC and select it for CPU
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module cgc_clock_ctrl
	import cgc_pkg::*;
#(
	parameter longint POR_HOLD_CYCLES = POR_CYCLES,
	parameter longint WD_RC_TICKS     = WD_TICKS
) (
	// clock and resets
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              sleep_reset_n,
	input  wire logic              global_reset_n,
	// oscillator ticks and cpu state
	input  wire logic              rc_tick,
	input  wire logic              xtal_tick,
	input  wire logic              ext_clk_tick,
	input  wire logic              cpu_halt,
	input  wire logic              wd_restart,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// clock outputs
	output logic                   cpu_clk_tick,
	output logic                   clk32k_tick,
	output logic                   clk1hz_tick,
	output logic                   cpu_run,
	output logic                   watchdog_timeout,
	// analog oscillator controls
	output logic                   rc_osc_on,
	output logic                   rc_bias_on,
	output logic                   xtal_osc_on,
	output logic                   rc_range,
	output logic [CRS_W-1:0]       rc_coarse,
	output logic [FINE_W-1:0]      rc_fine,
	output logic                   test_mode,
	// port pins
	output logic                   port_b_bit3,
	output logic                   port_b_bit3_oe,
	output logic                   port_b_bit2,
	output logic                   port_b_bit2_oe
);
	localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_HOLD_CYCLES - 64'd1);
	localparam logic [CNT_W-1:0] WD_LAST  = CNT_W'(WD_RC_TICKS - 64'd1);

	typedef struct packed {
		logic                   cpu_clock_select;
		logic                   external_clock_enable;
		logic                   rc_bias_keep;
		logic                   crystal_warmup_flag;
		logic                   crystal_osc_enable;
		logic                   rc_osc_enable;
		logic                   slow_clock_pin_output;
		logic                   cpu_clock_pin_output;
		logic                   rc_range_select;
		logic [CRS_W-1:0]       rc_coarse_trim;
		logic [FINE_W-1:0]      rc_fine_trim;
		logic                   test_bit;
		logic [TAP_W-1:0]       tap_sel;
		logic [HDIV_W-1:0]      hdiv;
		logic [LDIV_W-1:0]      ldiv;
		logic [WARM_W-1:0]      warm_cnt;
		logic [CNT_W-1:0]       por_cnt;
		logic                   por_done;
		logic [CNT_W-1:0]       wd_cnt;
		logic                   wd_to;
		logic                   t32k;
		logic                   t1hz;
		logic                   tcpu;
		logic                   cpu_lvl;
		logic                   pb3;
		logic                   pb2;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   aw_have;
		logic                   w_have;
		logic [ADDR_W-1:0]      aw_addr;
		logic [7:0]             wbyte;
		logic                   wlane;
		logic                   arready;
		logic                   rvalid;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
	} cgc_state_s;

	cgc_state_s q, d;

	function automatic cgc_state_s cold_state();
		cgc_state_s s;
		s = '0;
		s.rc_bias_keep        = 1'b1;
		s.rc_coarse_trim      = COARSE_RESET;
		s.crystal_warmup_flag = 1'b1;
		s.rc_osc_enable       = 1'b1;
		return s;
	endfunction : cold_state

	logic       rc_live, fast_tick, hdiv_src, tap_hit, xtal_ready;
	logic       aw_hs, w_hs, ar_hs, do_write, ok_addr;
	logic [7:0] rd_byte;

	always_comb begin
		d = q;
		// sources and dividers
		rc_live    = rc_tick && q.rc_osc_enable;
		hdiv_src   = q.external_clock_enable ? ext_clk_tick : rc_live;
		xtal_ready = q.crystal_osc_enable && !q.crystal_warmup_flag && xtal_tick;
		tap_hit    = hdiv_src && (&(q.hdiv | ~((HDIV_W'(2) << q.tap_sel) - HDIV_W'(1))));
		// external clock takes the fast path only once RC is switched off
		fast_tick  = (q.external_clock_enable && !q.rc_osc_enable) ? ext_clk_tick : rc_live;
		if (hdiv_src)
			d.hdiv = q.hdiv + HDIV_W'(1);
		d.t32k = q.crystal_osc_enable ? xtal_ready : tap_hit;
		d.t1hz = 1'b0;
		if (q.t32k) begin
			d.ldiv = q.ldiv + LDIV_W'(1);
			d.t1hz = &q.ldiv;
		end
		// crystal warm-up
		if (!q.crystal_osc_enable) begin
			d.crystal_warmup_flag = 1'b1;
			d.warm_cnt            = '0;
		end else if (q.crystal_warmup_flag && xtal_tick) begin
			d.warm_cnt = q.warm_cnt + WARM_W'(1);
			if (q.warm_cnt == WARM_LAST)
				d.crystal_warmup_flag = 1'b0;
		end
		// power-up hold
		if (!q.por_done) begin
			d.por_cnt = q.por_cnt + CNT_W'(1);
			if (q.por_cnt == POR_LAST)
				d.por_done = 1'b1;
		end
		// cpu clock
		d.tcpu = q.por_done && !cpu_halt && (q.cpu_clock_select ? q.t32k : fast_tick);
		if (q.tcpu)
			d.cpu_lvl = !q.cpu_lvl;
		d.pb3 = q.slow_clock_pin_output && q.ldiv[0];
		d.pb2 = q.cpu_clock_pin_output && q.cpu_lvl;
		// watchdog time base on trimmed RC ticks only
		d.wd_to = 1'b0;
		if (wd_restart) begin
			d.wd_cnt = '0;
		end else if (rc_tick) begin
			d.wd_cnt = q.wd_cnt + CNT_W'(1);
			if (q.wd_cnt == WD_LAST) begin
				d.wd_to  = 1'b1;
				d.wd_cnt = '0;
			end
		end
		// write channel
		aw_hs = s_axi_awvalid && q.awready;
		w_hs  = s_axi_wvalid && q.wready;
		if (aw_hs) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (w_hs) begin
			d.w_have = 1'b1;
			d.wbyte  = s_axi_wdata[7:0];
			d.wlane  = s_axi_wstrb[0];
		end
		do_write = q.aw_have && q.w_have && !q.bvalid;
		ok_addr  = 1'b1;
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (do_write) begin
			d.aw_have = 1'b0;
			d.w_have  = 1'b0;
			d.bvalid  = 1'b1;
			unique case (q.aw_addr)
				OFS_CLOCK_CTRL: if (q.wlane) begin
					d.cpu_clock_select      = q.wbyte[BIT_CPU_SEL];
					d.external_clock_enable = q.wbyte[BIT_EXT_EN];
					d.rc_bias_keep          = q.wbyte[BIT_BIAS_RC];
					d.crystal_osc_enable    = q.wbyte[BIT_XTAL_EN];
					d.rc_osc_enable         = q.wbyte[BIT_RC_EN];
				end
				OFS_MISC_OUT: if (q.wlane) begin
					d.slow_clock_pin_output = q.wbyte[BIT_OUT_16K];
					d.cpu_clock_pin_output  = q.wbyte[BIT_OUT_CPU];
				end
				OFS_DIV_CLEAR: if (q.wlane && q.wbyte[BIT_DIV_CLR])
					d.ldiv = '0;
				OFS_RC_TRIM1: if (q.wlane) begin
					d.rc_range_select = q.wbyte[BIT_RANGE];
					d.rc_coarse_trim  = q.wbyte[CRS_W-1:0];
				end
				OFS_RC_TRIM2: if (q.wlane)
					d.rc_fine_trim = q.wbyte[FINE_W-1:0];
				OFS_TEST_CTRL: if (q.wlane)
					d.test_bit = q.wbyte[0];
				OFS_TAP_SELECT: if (q.wlane)
					d.tap_sel = q.wbyte[TAP_W-1:0];
				OFS_STATUS: ;
				default: ok_addr = 1'b0;
			endcase
			d.bresp = ok_addr ? RESP_OKAY : RESP_SLVERR;
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready  = !d.w_have && !d.bvalid;
		// read channel
		ar_hs   = s_axi_arvalid && q.arready;
		rd_byte = '0;
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (ar_hs) begin
			d.rvalid = 1'b1;
			d.rresp  = RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_CLOCK_CTRL: begin
					rd_byte[BIT_CPU_SEL] = q.cpu_clock_select;
					rd_byte[BIT_EXT_EN]  = q.external_clock_enable;
					rd_byte[BIT_BIAS_RC] = q.rc_bias_keep;
					rd_byte[BIT_WARMUP]  = q.crystal_warmup_flag;
					rd_byte[BIT_XTAL_EN] = q.crystal_osc_enable;
					rd_byte[BIT_RC_EN]   = q.rc_osc_enable;
				end
				OFS_MISC_OUT: begin
					rd_byte[BIT_OUT_16K] = q.slow_clock_pin_output;
					rd_byte[BIT_OUT_CPU] = q.cpu_clock_pin_output;
				end
				OFS_DIV_CLEAR: rd_byte = '0;
				OFS_RC_TRIM1: begin
					rd_byte[BIT_RANGE]   = q.rc_range_select;
					rd_byte[CRS_W-1:0]   = q.rc_coarse_trim;
				end
				OFS_RC_TRIM2: rd_byte[FINE_W-1:0] = q.rc_fine_trim;
				OFS_TEST_CTRL: rd_byte[0] = q.test_bit;
				OFS_TAP_SELECT: rd_byte[TAP_W-1:0] = q.tap_sel;
				OFS_STATUS: begin
					rd_byte[BIT_POR_DONE] = q.por_done;
					rd_byte[BIT_STAT_WRM] = q.crystal_warmup_flag;
				end
				default: d.rresp = RESP_SLVERR;
			endcase
			d.rdata = {24'h000000, rd_byte};
		end
		d.arready = !d.rvalid;
		// group resets; the register write above loses to them
		if (!global_reset_n)
			d.test_bit = 1'b0;
		if (!sleep_reset_n) begin
			d.cpu_clock_select      = 1'b0;
			d.crystal_warmup_flag   = 1'b1;
			d.crystal_osc_enable    = 1'b0;
			d.rc_osc_enable         = 1'b1;
			d.slow_clock_pin_output = 1'b0;
			d.cpu_clock_pin_output  = 1'b0;
			d.warm_cnt              = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= cold_state();
		else
			q <= d;
	end

	assign s_axi_awready    = q.awready;
	assign s_axi_wready     = q.wready;
	assign s_axi_bvalid     = q.bvalid;
	assign s_axi_bresp      = q.bresp;
	assign s_axi_arready    = q.arready;
	assign s_axi_rvalid     = q.rvalid;
	assign s_axi_rresp      = q.rresp;
	assign s_axi_rdata      = q.rdata;
	assign cpu_clk_tick     = q.tcpu;
	assign clk32k_tick      = q.t32k;
	assign clk1hz_tick      = q.t1hz;
	assign cpu_run          = q.por_done;
	assign watchdog_timeout = q.wd_to;
	assign rc_osc_on        = q.rc_osc_enable;
	assign rc_bias_on       = q.rc_bias_keep;
	assign xtal_osc_on      = q.crystal_osc_enable;
	assign rc_range         = q.rc_range_select;
	assign rc_coarse        = q.rc_coarse_trim;
	assign rc_fine          = q.rc_fine_trim;
	assign test_mode        = q.test_bit;
	assign port_b_bit3      = q.pb3;
	assign port_b_bit3_oe   = q.slow_clock_pin_output;
	assign port_b_bit2      = q.pb2;
	assign port_b_bit2_oe   = q.cpu_clock_pin_output;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence warm_running_s;
		q.crystal_osc_enable && q.crystal_warmup_flag;
	endsequence

	por_hold_a: assert property (!q.por_done |-> !cpu_clk_tick && q.por_cnt <= POR_LAST)
		else $error("cpu clock ran during power-up hold");
	halt_stop_a: assert property ($past(cpu_halt) |-> !cpu_clk_tick)
		else $error("cpu clock ticked in halt");
	div_clear_a: assert property (do_write && q.aw_addr == OFS_DIV_CLEAR && q.wlane && q.wbyte[BIT_DIV_CLR]
		|=> q.ldiv == '0)
		else $error("low divider not cleared");
	sleep_clear_a: assert property (!sleep_reset_n |=> !q.cpu_clock_select && q.rc_osc_enable
		&& !q.crystal_osc_enable && !q.slow_clock_pin_output && !q.cpu_clock_pin_output)
		else $error("sleep reset left clock controls set");
	ext_keep_a: assert property (!sleep_reset_n && q.external_clock_enable && !do_write
		|=> q.external_clock_enable)
		else $error("sleep reset cleared external clock enable");
	warm_mask_a: assert property (warm_running_s |=> !clk32k_tick)
		else $error("crystal clock passed during warm-up");
	warm_end_a: assert property (warm_running_s ##0 (xtal_tick && q.warm_cnt == WARM_LAST && sleep_reset_n)
		|=> !q.crystal_warmup_flag)
		else $error("warm-up flag not cleared after count");
	one_hz_a: assert property (clk32k_tick && (&q.ldiv) |=> clk1hz_tick)
		else $error("missing 1 Hz tick at divider wrap");
	xtal_src_a: assert property (q.crystal_osc_enable && !xtal_tick |=> !clk32k_tick)
		else $error("32 kHz tick without crystal tick");
	wd_fire_a: assert property (rc_tick && !wd_restart && q.wd_cnt == WD_LAST
		|=> watchdog_timeout ##1 !watchdog_timeout)
		else $error("watchdog timeout not a single pulse at terminal count");
	pin16k_a: assert property (!q.slow_clock_pin_output |=> !port_b_bit3)
		else $error("port b bit 3 driven while disabled");
	div_read_a: assert property (ar_hs && s_axi_araddr == OFS_DIV_CLEAR |=> s_axi_rdata == 32'h00000000)
		else $error("divider clear register read nonzero");
	pin_cpu_a: assert property (!q.cpu_clock_pin_output |=> !port_b_bit2)
		else $error("port b bit 2 driven while disabled");
	cpu_slow_a: assert property (q.por_done && !cpu_halt && q.cpu_clock_select && !q.t32k |=> !cpu_clk_tick)
		else $error("cpu clock ticked off the 32 kHz clock");
	tap_quiet_a: assert property (!q.crystal_osc_enable && !hdiv_src |=> !clk32k_tick)
		else $error("32 kHz tick without a high divider input tick");
	sleep_warm_a: assert property (!sleep_reset_n |=> q.crystal_warmup_flag && q.warm_cnt == '0)
		else $error("sleep reset left crystal warm-up cleared");
endmodule : cgc_clock_ctrl

// ==== cgc_pkg.sv ====
// Purpose: shared constants for the clock generation control block
// Assumes: 25 MHz bus clock, AXI4-Lite register access, 8-bit registers in the low byte lane
// Notes: register offsets are byte addresses
package cgc_pkg;
	// register offsets
	localparam logic [7:0] OFS_CLOCK_CTRL = 8'h00;
	localparam logic [7:0] OFS_MISC_OUT   = 8'h04;
	localparam logic [7:0] OFS_DIV_CLEAR  = 8'h08;
	localparam logic [7:0] OFS_RC_TRIM1   = 8'h0C;
	localparam logic [7:0] OFS_RC_TRIM2   = 8'h10;
	localparam logic [7:0] OFS_TEST_CTRL  = 8'h14;
	localparam logic [7:0] OFS_TAP_SELECT = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1C;
	localparam int         ADDR_W         = 8;
	// register field positions
	localparam int BIT_CPU_SEL  = 7;
	localparam int BIT_EXT_EN   = 5;
	localparam int BIT_BIAS_RC  = 4;
	localparam int BIT_WARMUP   = 3;
	localparam int BIT_XTAL_EN  = 1;
	localparam int BIT_RC_EN    = 0;
	localparam int BIT_OUT_16K  = 1;
	localparam int BIT_OUT_CPU  = 0;
	localparam int BIT_DIV_CLR  = 0;
	localparam int BIT_RANGE    = 4;
	localparam int BIT_POR_DONE = 0;
	localparam int BIT_STAT_WRM = 1;
	// reset values
	localparam logic [3:0] COARSE_RESET = 4'h1;
	// widths
	localparam int HDIV_W  = 8;
	localparam int LDIV_W  = 15;
	localparam int TAP_W   = 3;
	localparam int CRS_W   = 4;
	localparam int FINE_W  = 6;
	localparam int CNT_W   = 24;
	localparam int WARM_W  = 16;
	// timing
	localparam longint CLK_HZ      = 64'd25000000;
	localparam longint POR_MIN_MS  = 64'd5;
	localparam longint POR_CYCLES  = (POR_MIN_MS * CLK_HZ + 64'd999) / 64'd1000;
	localparam longint WD_MIN_S    = 64'd2;
	localparam longint RC_NOM_HZ   = 64'd80000;
	localparam longint WD_TICKS    = WD_MIN_S * RC_NOM_HZ;
	localparam logic [WARM_W-1:0] WARM_LAST = 16'h7FFF;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cgc_pkg

// ==== testbench.sv ====
// Purpose: self-checking bench for the clock generation control block
// Assumes: short power-up hold and watchdog counts set by parameter; oscillator ticks made here
// Notes: warm-up and one 1 Hz period cost about 33k cycles each; the cycle ceiling sits above both
`timescale 1ns/1ns
module testbench;
	import cgc_pkg::*;
	localparam int HOLD = 20;
	localparam int WDT  = 16;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} cgc_row_s;
	logic                aclk, aresetn, sleep_reset_n, global_reset_n;
	logic                rc_tick, xtal_tick, ext_clk_tick, cpu_halt, wd_restart;
	logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
	logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0]         s_axi_wdata, s_axi_rdata;
	logic [3:0]          s_axi_wstrb;
	logic [1:0]          s_axi_bresp, s_axi_rresp, resp;
	logic                cpu_clk_tick, clk32k_tick, clk1hz_tick, cpu_run, watchdog_timeout;
	logic                rc_osc_on, rc_bias_on, xtal_osc_on, rc_range, test_mode;
	logic [CRS_W-1:0]    rc_coarse;
	logic [FINE_W-1:0]   rc_fine;
	logic                port_b_bit3, port_b_bit3_oe, port_b_bit2, port_b_bit2_oe, xtal_run, p3, p2;
	logic [31:0]         rd;
	int                  err_count, compares, cyc, rc_per, xtal_cnt, n, c1, c2;
	cgc_row_s            rows [11] = '{
		'{OFS_CLOCK_CTRL, 8'hFF, 8'hBB, RESP_OKAY},
		'{OFS_CLOCK_CTRL, 8'h11, 8'h19, RESP_OKAY},
		'{OFS_MISC_OUT, 8'hFF, 8'h03, RESP_OKAY},
		'{OFS_MISC_OUT, 8'h00, 8'h00, RESP_OKAY},
		'{OFS_DIV_CLEAR, 8'hFF, 8'h00, RESP_OKAY},
		'{OFS_RC_TRIM1, 8'hFF, 8'h1F, RESP_OKAY},
		'{OFS_RC_TRIM1, 8'h0A, 8'h0A, RESP_OKAY},
		'{OFS_RC_TRIM2, 8'hFF, 8'h3F, RESP_OKAY},
		'{OFS_TEST_CTRL, 8'hFF, 8'h01, RESP_OKAY},
		'{OFS_TEST_CTRL, 8'h00, 8'h00, RESP_OKAY},
		'{8'h20, 8'h5A, 8'h00, RESP_SLVERR}};

	cgc_clock_ctrl #(.POR_HOLD_CYCLES(HOLD), .WD_RC_TICKS(WDT)) u_cgc_clock_ctrl (
		.aclk, .aresetn, .sleep_reset_n, .global_reset_n, .rc_tick, .xtal_tick, .ext_clk_tick,
		.cpu_halt, .wd_restart, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cpu_clk_tick, .clk32k_tick, .clk1hz_tick, .cpu_run, .watchdog_timeout,
		.rc_osc_on, .rc_bias_on, .xtal_osc_on, .rc_range, .rc_coarse, .rc_fine, .test_mode,
		.port_b_bit3, .port_b_bit3_oe, .port_b_bit2, .port_b_bit2_oe);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// oscillators as tick pulses; the cycle ceiling cuts any hang short
	always @(posedge aclk) begin
		cyc          <= cyc + 1;
		rc_tick      <= (cyc % rc_per) == 0;
		xtal_tick    <= xtal_run;
		ext_clk_tick <= cyc[0];
		if (xtal_run)
			xtal_cnt <= xtal_cnt + 1;
		if (cyc == 80000) begin
			$display("CHECK FAILED cycle ceiling expected done seen hang");
			err_count++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rng(input string what, input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : rng

	task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw, w;
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		@(posedge aclk);
		ar = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ar && s_axi_arready) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : axr

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk($sformatf("read data %h", a), {24'h000000, e}, d);
		chk($sformatf("read resp %h", a), {30'h0, er}, {30'h0, r});
	endtask : rdchk

	// counts cpu and 32 kHz ticks over a window of cycles
	task automatic cnt(input int len, output int nc, output int ns);
		nc = 0;
		ns = 0;
		repeat (len) begin
			@(posedge aclk);
			nc += (cpu_clk_tick === 1'b1);
			ns += (clk32k_tick === 1'b1);
		end
	endtask : cnt

	initial begin
		{aresetn, cpu_halt, wd_restart, xtal_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{rc_tick, xtal_tick, ext_clk_tick} = '0;
		{sleep_reset_n, global_reset_n} = 2'b11;
		{err_count, compares, cyc, xtal_cnt} = '0;
		rc_per = 4;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			axw(rows[i].a, rows[i].d, resp);
			chk("write resp", {30'h0, rows[i].r}, {30'h0, resp});
			rdchk(rows[i].a, rows[i].e, rows[i].r);
		end
		chk("trim outputs", {rc_range, rc_coarse, rc_fine}, {1'b0, 4'hA, 6'h3F});
		// cold reset in mid-run, then the power-up hold length
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (n = 0; n < 100 && cpu_run !== 1'b1; n++)
			@(posedge aclk);
		rng("power-up hold", n, HOLD, HOLD + 2);
		chk("osc controls", {rc_osc_on, rc_bias_on, xtal_osc_on}, 3'b110);
		rdchk(OFS_CLOCK_CTRL, 8'h19, RESP_OKAY);
		rdchk(OFS_MISC_OUT, 8'h00, RESP_OKAY);
		rdchk(OFS_RC_TRIM1, 8'h01, RESP_OKAY);
		rdchk(OFS_RC_TRIM2, 8'h00, RESP_OKAY);
		rdchk(OFS_STATUS, 8'h03, RESP_OKAY);
		// pin outputs, then sleep reset keeps the cold-only bits
		axw(OFS_MISC_OUT, 8'h03, resp);
		c1 = 0;
		c2 = 0;
		{p3, p2} = {port_b_bit3, port_b_bit2};
		repeat (64) begin
			@(posedge aclk);
			c1 += (port_b_bit3 !== p3);
			c2 += (port_b_bit2 !== p2);
			{p3, p2} = {port_b_bit3, port_b_bit2};
		end
		chk("pin enables", {port_b_bit3_oe, port_b_bit2_oe}, 2'b11);
		rng("16 kHz pin edges", c1, 7, 9);
		rng("cpu clock pin edges", c2, 15, 17);
		axw(OFS_CLOCK_CTRL, 8'hB2, resp);
		axw(OFS_RC_TRIM1, 8'h15, resp);
		@(posedge aclk);
		sleep_reset_n <= 1'b0;
		@(posedge aclk);
		sleep_reset_n <= 1'b1;
		rdchk(OFS_CLOCK_CTRL, 8'h39, RESP_OKAY);
		rdchk(OFS_MISC_OUT, 8'h00, RESP_OKAY);
		rdchk(OFS_RC_TRIM1, 8'h15, RESP_OKAY);
		chk("pin enables off", {port_b_bit3_oe, port_b_bit2_oe}, 2'b00);
		axw(OFS_TEST_CTRL, 8'h01, resp);
		chk("test mode set", {31'h0, test_mode}, 32'h1);
		@(posedge aclk);
		global_reset_n <= 1'b0;
		@(posedge aclk);
		global_reset_n <= 1'b1;
		rdchk(OFS_TEST_CTRL, 8'h00, RESP_OKAY);
		chk("test mode cleared", {31'h0, test_mode}, 32'h0);
		rdchk(OFS_RC_TRIM1, 8'h15, RESP_OKAY);
		// high divider taps and CPU clock on the RC oscillator, then on the external clock
		axw(OFS_CLOCK_CTRL, 8'h11, resp);
		for (int t = 0; t < 3; t++) begin
			axw(OFS_TAP_SELECT, t[7:0], resp);
			cnt(96, c1, c2);
			rng("32 kHz tick count", c2, 96 / (8 << t) - 1, 96 / (8 << t) + 1);
		end
		axw(OFS_TAP_SELECT, 8'h00, resp);
		cnt(96, c1, c2);
		rng("cpu on RC", c1, 23, 25);
		cpu_halt <= 1'b1;
		repeat (4) @(posedge aclk);
		cnt(96, c1, c2);
		rng("cpu ticks in halt", c1, 0, 0);
		rng("32 kHz in halt", c2, 11, 13);
		cpu_halt <= 1'b0;
		axw(OFS_CLOCK_CTRL, 8'h91, resp);
		cnt(96, c1, c2);
		rng("cpu on 32 kHz", c1, 11, 13);
		axw(OFS_CLOCK_CTRL, 8'h30, resp);
		cnt(96, c1, c2);
		rng("cpu on external", c1, 47, 49);
		rng("32 kHz on external", c2, 23, 25);
		// watchdog keeps counting RC ticks while the external clock runs
		axw(OFS_CLOCK_CTRL, 8'h31, resp);
		@(posedge aclk);
		wd_restart <= 1'b1;
		@(posedge aclk);
		wd_restart <= 1'b0;
		c1 = 0;
		// the first look still sees the free-running time base from before the restart
		for (n = 0; n < 200 && (n == 0 || watchdog_timeout !== 1'b1); n++) begin
			@(posedge aclk);
			c1 += (rc_tick === 1'b1);
		end
		rng("RC ticks to watchdog", c1, WDT, WDT + 1);
		// crystal warm-up, then 32 kHz follows the crystal
		axw(OFS_CLOCK_CTRL, 8'h13, resp);
		xtal_run <= 1'b1;
		rd = 32'h2;
		while (rd[1] === 1'b1)
			axr(OFS_STATUS, rd, resp);
		rng("crystal warm-up ticks", xtal_cnt, 32768, 32780);
		rdchk(OFS_CLOCK_CTRL, 8'h13, RESP_OKAY);
		cnt(96, c1, c2);
		rng("32 kHz on crystal", c2, 94, 96);
		// divider clear restarts the low chain; one full wrap takes 32768 crystal ticks
		axw(OFS_DIV_CLEAR, 8'h01, resp);
		for (n = 0; n < 40000 && (n == 0 || clk1hz_tick !== 1'b1); n++)
			@(posedge aclk);
		rng("1 Hz after divider clear", n, 32767, 32769);
		end_of_test();
	end
endmodule : testbench
